// File: rtl/cdmc_ctrl.sv
// Host-side controller that sequences the pins of a cached DRAM module
// Operation
// - On reads the row strobe returns high once the row is cached, and cached data stay readable.
// - The column latch strobe is high at every row-strobe fall, refresh cycles included.
// - Chip select stays low through any read or write, and strobes rows only for refresh when high.
// - A 9-bit column address presented later selects cached read data or the write column.
`timescale 1ns/100ps
`default_nettype none
`include "cdmc_regs.svh"

module cdmc_ctrl #(
    parameter int ROW_CYC = `CDMC_ROW_CYC,
    parameter int PRE_CYC = `CDMC_PRE_CYC,
    parameter int ACC_CYC = `CDMC_ACC_CYC,
    parameter int WE_CYC = `CDMC_WE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input var cdmc_pkg::cdmc_req_s req,
    output logic req_ready,
    output logic [`CDMC_DQ_W-1:0] rdata,
    output logic rvalid,
    output var cdmc_pkg::cdmc_pins_s pins,
    input wire logic [`CDMC_DQ_W-1:0] dq_i
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        cdmc_pkg::cdmc_state_e st;
        logic [`CDMC_CNT_W-1:0] cnt;
        cdmc_pkg::cdmc_req_s req;
        logic [`CDMC_GROUPS-1:0] need;
        logic [`CDMC_GROUPS-1:0] hit;
        cdmc_pkg::cdmc_pins_s pins;
        logic [`CDMC_DQ_W-1:0] rdata;
        logic rvalid;
        logic ready;
    } cdmc_ctrl_s;

    cdmc_ctrl_s q;
    cdmc_ctrl_s d;
    cdmc_ctrl_s rst_val;

    logic [`CDMC_ROW_W-1:0] tag_row [`CDMC_GROUPS];
    logic [`CDMC_GROUPS-1:0] tag_valid;
    logic [`CDMC_GROUPS-1:0] tag_load;
    logic [`CDMC_GROUPS-1:0] req_need;
    logic [`CDMC_GROUPS-1:0] req_hit;
    logic [`CDMC_GROUPS-1:0] strobe;

    always_comb
    begin
        rst_val = '0;
        rst_val.st = cdmc_pkg::CDMC_IDLE;
        rst_val.ready = 1'b1;
        rst_val.pins.row_strobe_n = `CDMC_ROW_IDLE;
        rst_val.pins.col_latch_n = `CDMC_LATCH_IDLE;
        rst_val.pins.refresh_sel_n = 1'b1;
        rst_val.pins.write_en_n = 1'b1;
        rst_val.pins.out_gate_n = 1'b1;
        rst_val.pins.chip_sel_n = 1'b1;
    end

    // ****************************************************************
    // Row cache tracking, one tracker per row-strobe group
    // ****************************************************************
    // Group 0 holds lanes 0,1; group 1 holds lanes 2,3 and parity
    assign req_need = req.refresh ? `CDMC_ROW_IDLE :
        {|req.lane_en[4:2], |req.lane_en[1:0]};

    for (genvar g = 0; g < `CDMC_GROUPS; g++)
    begin : g_tag
        cdmc_tag #(
            .ROW_W(`CDMC_ROW_W)
        ) u_tag (
            .clk(clk),
            .rst(rst),
            .load(tag_load[g]),
            .row_in(q.req.row),
            .tag_row_q(tag_row[g]),
            .tag_valid_q(tag_valid[g])
        );
        assign req_hit[g] = tag_valid[g] && (tag_row[g] == req.row);
    end

    // Array read just filled the cache of every strobed group
    assign tag_load = (q.st == cdmc_pkg::CDMC_ROW && q.cnt == '0 && !q.req.refresh
        && !q.req.write) ? ~q.pins.row_strobe_n : '0;

    // Writes always need an array cycle; reads only on a miss
    assign strobe = q.req.refresh ? `CDMC_ROW_IDLE :
        (q.req.write ? q.need : (q.need & ~q.hit));

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb
    begin
        logic go_col;
        go_col = 1'b0;
        d = q;
        d.rvalid = 1'b0;
        case (q.st)
            cdmc_pkg::CDMC_IDLE:
            begin
                if (req_valid && q.ready)
                begin
                    d.req = req;
                    d.need = req_need;
                    d.hit = req_hit;
                    d.ready = 1'b0;
                    d.st = cdmc_pkg::CDMC_SETUP;
                    // Refresh may run with the module asleep
                    d.pins.chip_sel_n = req.refresh;
                    d.pins.multiplexed_address = req.row;
                    d.pins.write_sel = req.write & ~req.refresh;
                    d.pins.refresh_sel_n = ~req.refresh;
                end
            end
            cdmc_pkg::CDMC_SETUP:
            begin
                if (strobe != '0)
                begin
                    // Column latches stay high here: transparent at the fall
                    d.pins.row_strobe_n = ~strobe;
                    d.cnt = `CDMC_CNT_W'(ROW_CYC - 1);
                    d.st = cdmc_pkg::CDMC_ROW;
                end
                else
                begin
                    go_col = 1'b1;
                end
            end
            cdmc_pkg::CDMC_ROW:
            begin
                if (q.cnt != '0)
                begin
                    d.cnt = q.cnt - `CDMC_CNT_W'(1);
                end
                else if (q.req.refresh)
                begin
                    d.pins.row_strobe_n = `CDMC_ROW_IDLE;
                    d.pins.refresh_sel_n = 1'b1;
                    d.cnt = `CDMC_CNT_W'(PRE_CYC - 1);
                    d.st = cdmc_pkg::CDMC_PRE;
                end
                else
                begin
                    go_col = 1'b1;
                end
            end
            cdmc_pkg::CDMC_COL:
            begin
                d.st = cdmc_pkg::CDMC_XFER;
                if (q.req.write)
                begin
                    // Lane strobe and write strobe low together start the write
                    d.pins.col_latch_n = ~q.req.lane_en;
                    d.pins.write_en_n = 1'b0;
                    d.cnt = `CDMC_CNT_W'(WE_CYC - 1);
                end
                else
                begin
                    d.cnt = `CDMC_CNT_W'(ACC_CYC - 1);
                end
            end
            cdmc_pkg::CDMC_XFER:
            begin
                if (q.cnt != '0)
                begin
                    d.cnt = q.cnt - `CDMC_CNT_W'(1);
                end
                else
                begin
                    if (!q.req.write)
                    begin
                        d.rdata = dq_i;
                        d.rvalid = 1'b1;
                    end
                    d.pins = rst_val.pins;
                    d.pins.multiplexed_address = q.pins.multiplexed_address;
                    d.cnt = `CDMC_CNT_W'(PRE_CYC - 1);
                    d.st = cdmc_pkg::CDMC_PRE;
                end
            end
            cdmc_pkg::CDMC_PRE:
            begin
                // Honours row precharge before the next fall
                if (q.cnt != '0)
                begin
                    d.cnt = q.cnt - `CDMC_CNT_W'(1);
                end
                else
                begin
                    d.pins = rst_val.pins;
                    d.ready = 1'b1;
                    d.st = cdmc_pkg::CDMC_IDLE;
                end
            end
            default:
            begin
                d = rst_val;
            end
        endcase
        if (go_col)
        begin
            d.st = cdmc_pkg::CDMC_COL;
            d.pins.multiplexed_address = {2'h0, q.req.col};
            if (q.req.write)
            begin
                d.pins.dq_o = q.req.wdata;
                d.pins.dq_oe = 1'b1;
            end
            else
            begin
                // Early precharge; cached row still readable
                d.pins.row_strobe_n = `CDMC_ROW_IDLE;
                d.pins.out_gate_n = 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q <= rst_val;
        end
        else
        begin
            q <= d;
        end
    end

    assign pins = q.pins;
    assign req_ready = q.ready;
    assign rdata = q.rdata;
    assign rvalid = q.rvalid;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_latch_at_fall: assert property (
        ($fell(q.pins.row_strobe_n[0]) || $fell(q.pins.row_strobe_n[1]))
        && q.pins.refresh_sel_n |-> q.pins.col_latch_n == `CDMC_LATCH_IDLE)
        else $error("Column latch low at row strobe fall");
    chk_cs_row_fall: assert property (
        ($fell(q.pins.row_strobe_n[0]) || $fell(q.pins.row_strobe_n[1]))
        && q.pins.refresh_sel_n |-> !q.pins.chip_sel_n)
        else $error("Row strobe fell with chip select high");
    chk_cs_write: assert property (
        !q.pins.write_en_n || q.pins.dq_oe |-> !q.pins.chip_sel_n)
        else $error("Write pins active with chip select high");
    chk_row_early: assert property (
        $fell(q.pins.row_strobe_n[0]) && !q.pins.write_sel && q.pins.refresh_sel_n
        |-> ##[1:8] q.pins.row_strobe_n[0] && !q.pins.out_gate_n)
        else $error("Read row strobe not released early");
    chk_col_addr: assert property (
        q.st == cdmc_pkg::CDMC_COL |-> q.pins.multiplexed_address == {2'h0, q.req.col}
        ##1 q.pins.multiplexed_address == $past(q.pins.multiplexed_address))
        else $error("Column address not presented");
    chk_hit_no_row: assert property (
        q.st == cdmc_pkg::CDMC_SETUP && !q.req.write && !q.req.refresh
        && (q.need & ~q.hit) == '0 |=> q.pins.row_strobe_n == `CDMC_ROW_IDLE
        && q.st == cdmc_pkg::CDMC_COL)
        else $error("Row strobe pulsed on cache hit");
    chk_gate_no_drive: assert property (
        !q.pins.out_gate_n |-> !q.pins.dq_oe && !q.pins.write_sel)
        else $error("Output gate open while driving data");

    cov_read_miss: cover property (
        q.st == cdmc_pkg::CDMC_ROW && !q.req.write && !q.req.refresh ##[1:8] rvalid);
    cov_read_hit: cover property (
        q.st == cdmc_pkg::CDMC_SETUP && !q.req.write && !q.req.refresh
        ##1 q.st == cdmc_pkg::CDMC_COL);
    cov_write: cover property (!q.pins.write_en_n);
    cov_refresh: cover property (!q.pins.refresh_sel_n && q.pins.row_strobe_n == 2'h0);

endmodule : cdmc_ctrl

`default_nettype wire

// File: rtl/cdmc_regs.svh
// Timing counts and pin idle values for the cached DRAM module controller
`ifndef CDMC_REGS_SVH
`define CDMC_REGS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define CDMC_ROW_W 11
`define CDMC_COL_W 9
`define CDMC_DQ_W 36
`define CDMC_LANES 5
`define CDMC_GROUPS 2
`define CDMC_CNT_W 4

// ****************************************************************
// Timing, in ns, and derived cycle counts
// ****************************************************************
`define CDMC_CLK_NS 50
`define CDMC_T_ROW_LOW_NS 35
`define CDMC_T_PRE_NS 30
`define CDMC_T_COL_ACC_NS 15
`define CDMC_T_WR_PULSE_NS 5
`define CDMC_CYC(ns) ((((ns) + `CDMC_CLK_NS - 1) / `CDMC_CLK_NS) < 1 ? 1 : \
    (((ns) + `CDMC_CLK_NS - 1) / `CDMC_CLK_NS))
`define CDMC_ROW_CYC `CDMC_CYC(`CDMC_T_ROW_LOW_NS)
`define CDMC_PRE_CYC `CDMC_CYC(`CDMC_T_PRE_NS)
`define CDMC_ACC_CYC `CDMC_CYC(`CDMC_T_COL_ACC_NS)
`define CDMC_WE_CYC `CDMC_CYC(`CDMC_T_WR_PULSE_NS)

// ****************************************************************
// Idle pin levels
// ****************************************************************
`define CDMC_ROW_IDLE 2'h3
`define CDMC_LATCH_IDLE 5'h1f

`endif

// File: rtl/cdmc_pkg.sv
// Types shared by the cached DRAM module controller
`include "cdmc_regs.svh"

package cdmc_pkg;

    // ****************************************************************
    // Sequencer states, Gray coded along the access path
    // ****************************************************************
    typedef enum logic [2:0] {
        CDMC_IDLE = 3'h0,
        CDMC_SETUP = 3'h1,
        CDMC_ROW = 3'h3,
        CDMC_COL = 3'h2,
        CDMC_XFER = 3'h6,
        CDMC_PRE = 3'h7
    } cdmc_state_e;

    // ****************************************************************
    // Module pins driven by the controller
    // ****************************************************************
    typedef struct packed {
        logic [`CDMC_GROUPS-1:0] row_strobe_n;
        logic [`CDMC_LANES-1:0] col_latch_n;
        logic [`CDMC_ROW_W-1:0] multiplexed_address;
        logic write_sel;
        logic refresh_sel_n;
        logic write_en_n;
        logic out_gate_n;
        logic chip_sel_n;
        logic [`CDMC_DQ_W-1:0] dq_o;
        logic dq_oe;
    } cdmc_pins_s;

    // ****************************************************************
    // User request
    // ****************************************************************
    typedef struct packed {
        logic write;
        logic refresh;
        logic [`CDMC_LANES-1:0] lane_en;
        logic [`CDMC_ROW_W-1:0] row;
        logic [`CDMC_COL_W-1:0] col;
        logic [`CDMC_DQ_W-1:0] wdata;
    } cdmc_req_s;

endpackage : cdmc_pkg

// File: rtl/cdmc_tag.sv
// Last-read-row tracker for one row-strobe group
`timescale 1ns/100ps
`default_nettype none

module cdmc_tag #(
    parameter int ROW_W = 11
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [ROW_W-1:0] row_in,
    output logic [ROW_W-1:0] tag_row_q,
    output logic tag_valid_q
);

    typedef struct packed {
        logic [ROW_W-1:0] row;
        logic valid;
    } cdmc_tag_s;

    cdmc_tag_s q;
    cdmc_tag_s d;

    always_comb
    begin
        d = q;
        if (load)
        begin
            d.row = row_in;
            d.valid = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign tag_row_q = q.row;
    assign tag_valid_q = q.valid;

endmodule : cdmc_tag

`default_nettype wire

// File: dv/cdmc_dev_model.sv
// Behavioural model of the cached DRAM module on the far side of the pins
`timescale 1ns/100ps
`default_nettype none

module cdmc_dev_model (
    input wire logic clk,
    input var cdmc_pkg::cdmc_pins_s pins,
    output logic [35:0] dq_i,
    output int err_count
);
    logic [35:0] mem [logic [19:0]];
    logic [10:0] row_q [2];
    logic [10:0] cache_row [2];
    logic [8:0] col_lat [5];
    logic [35:0] last_q = 36'h0;
    logic [35:0] rd;
    int refresh_cnt = 0;
    int strobe_err = 0;
    int fight_err = 0;

    assign err_count = strobe_err + fight_err;

    function automatic logic [35:0] lane_mask(input int l);
        case (l)
            0: return 36'h0000000ff;
            1: return 36'h00001fe00;
            2: return 36'h003fc0000;
            3: return 36'h7f8000000;
            default: return 36'h804020100;
        endcase
    endfunction : lane_mask

    function automatic logic [35:0] peek(input logic [19:0] k);
        return mem.exists(k) ? mem[k] : 36'h0;
    endfunction : peek

    task automatic row_fall(input int g);
        if (!pins.refresh_sel_n)
            refresh_cnt++; // Own counter, address pins ignored
        else
        begin
            if (pins.chip_sel_n || pins.col_latch_n !== 5'h1f)
                strobe_err++;
            row_q[g] = pins.multiplexed_address;
            if (!pins.write_sel)
                cache_row[g] = pins.multiplexed_address;
        end
    endtask : row_fall

    always @(negedge pins.row_strobe_n[0]) row_fall(0);
    always @(negedge pins.row_strobe_n[1]) row_fall(1);

    always @(pins or last_q)
    begin
        rd = 36'h0;
        for (int l = 0; l < 5; l++)
        begin
            if (pins.col_latch_n[l])
                col_lat[l] = pins.multiplexed_address[8:0];
            else if (!pins.write_en_n && !pins.chip_sel_n)
                mem[{row_q[l > 1], col_lat[l]}] = (peek({row_q[l > 1], col_lat[l]}) &
                    ~lane_mask(l)) | (pins.dq_o & lane_mask(l));
            rd |= peek({cache_row[l > 1], col_lat[l]}) & lane_mask(l);
        end
        // Released pins toggle each cycle so a stale word never passes
        dq_i = (!pins.out_gate_n && !pins.chip_sel_n) ? rd : ~last_q;
    end

    always @(posedge clk)
    begin
        last_q <= dq_i;
        if (!pins.out_gate_n && pins.dq_oe)
            fight_err++; // Both sides driving data
    end
endmodule : cdmc_dev_model

`default_nettype wire

// File: dv/cdmc_ctrl_bench.sv
// Self-checking bench for the cached DRAM module controller
`timescale 1ns/100ps
`default_nettype none

module cdmc_ctrl_bench;
    localparam logic [35:0] d1 = 36'h9a5c3e187;
    localparam logic [35:0] d2 = 36'h3c1f0e2d5;
    localparam logic [35:0] d3 = 36'h5e6d7c8b9;
    localparam logic [35:0] d4 = 36'ha1b2c3d4e;
    localparam logic [35:0] lo = 36'h00001feff;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    cdmc_pkg::cdmc_req_s req = '0;
    logic req_ready;
    logic rvalid;
    logic [35:0] rdata;
    logic [35:0] dq_i;
    cdmc_pkg::cdmc_pins_s pins;
    logic [1:0] strobe_prev = 2'h3;
    logic [4:0] latch_seen = 5'h1f;
    logic [35:0] got;
    int miscompares = 0;
    int check_count = 0;
    int model_err;
    int falls0 = 0;
    int falls1 = 0;
    int lat;
    int f0;
    int f1;

    cdmc_ctrl dut (
        .clk(clk),
        .rst(rst),
        .req_valid(req_valid),
        .req(req),
        .req_ready(req_ready),
        .rdata(rdata),
        .rvalid(rvalid),
        .pins(pins),
        .dq_i(dq_i)
    );

    cdmc_dev_model model (
        .clk(clk),
        .pins(pins),
        .dq_i(dq_i),
        .err_count(model_err)
    );

    initial
    begin
        forever #25 clk = ~clk;
    end

    // Mid-cycle sampling, clear of the edge that launches the pins
    always @(negedge clk)
    begin
        strobe_prev <= pins.row_strobe_n;
        if (strobe_prev[0] === 1'b1 && pins.row_strobe_n[0] === 1'b0)
            falls0++;
        if (strobe_prev[1] === 1'b1 && pins.row_strobe_n[1] === 1'b0)
            falls1++;
        if (pins.write_en_n === 1'b0)
            latch_seen <= pins.col_latch_n;
    end

    task automatic cmp_word(input logic [35:0] g, input logic [35:0] e);
        check_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp_word

    task automatic cmp_int(input int g, input int e);
        check_count++;
        if (g != e)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp_int

    function automatic logic [35:0] idle_bits();
        return {23'h0, pins.row_strobe_n, pins.col_latch_n, pins.write_sel,
            pins.refresh_sel_n, pins.write_en_n, pins.out_gate_n, pins.chip_sel_n, pins.dq_oe};
    endfunction : idle_bits

    task automatic issue(input logic wr, input logic rf, input logic [4:0] lanes,
        input logic [10:0] row, input logic [8:0] col, input logic [35:0] wd);
        logic taken;
        int n;
        taken = 1'b0;
        n = 0;
        req = '{write: wr, refresh: rf, lane_en: lanes, row: row, col: col, wdata: wd};
        req_valid = 1'b1;
        // Ready read between edges is what the next edge sees
        while (!taken && n < 40)
        begin
            taken = (req_ready === 1'b1);
            @(posedge clk);
            #1;
            n++;
        end
        req_valid = 1'b0;
        lat = -1;
        // Ready stays low for at least two samples once taken
        for (n = 0; n < 40 && !(n > 1 && req_ready === 1'b1); n++)
        begin
            if (rvalid === 1'b1)
            begin
                got = rdata;
                lat = n;
            end
            @(posedge clk);
            #1;
        end
        cmp_int(taken && n < 40, 1);
    endtask : issue

    task automatic t_reset;
        cmp_word(idle_bits(), 36'h1fde);
        cmp_word({34'h0, req_ready, rvalid}, 36'h2);
        cmp_word(rdata, 36'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_miss_hit;
        issue(1, 0, 5'h1f, 11'h5a3, 9'h1c4, d1);
        cmp_word({31'h0, latch_seen}, 36'h0);
        issue(1, 0, 5'h1f, 11'h5a3, 9'h0f3, d2);
        f0 = falls0 + falls1;
        issue(0, 0, 5'h1f, 11'h5a3, 9'h1c4, '0);
        cmp_word(got, d1);
        cmp_int(falls0 + falls1 - f0, 2);
        cmp_int(lat, 4);
        f1 = lat;
        f0 = falls0 + falls1;
        issue(0, 0, 5'h1f, 11'h5a3, 9'h0f3, '0);
        cmp_word(got, d2);
        cmp_int(falls0 + falls1 - f0, 0);
        cmp_int(lat, f1 - 1);
        cmp_word(idle_bits(), 36'h1fde);
        $display("test miss_hit done");
    endtask : t_miss_hit

    task automatic t_refresh;
        f0 = falls0 + falls1;
        issue(0, 1, 5'h1f, 11'h7ff, 9'h000, '0);
        cmp_int(falls0 + falls1 - f0, 2);
        f0 = falls0 + falls1;
        issue(0, 0, 5'h1f, 11'h5a3, 9'h1c4, '0);
        cmp_word(got, d1);
        cmp_int(falls0 + falls1 - f0, 0);
        $display("test refresh done");
    endtask : t_refresh

    task automatic t_lanes;
        f0 = falls0;
        f1 = falls1;
        issue(1, 0, 5'h03, 11'h5a3, 9'h1c4, d3);
        cmp_int(falls0 - f0, 1);
        cmp_int(falls1 - f1, 0);
        cmp_word({31'h0, latch_seen}, 36'h1c);
        issue(0, 0, 5'h1f, 11'h5a3, 9'h1c4, '0);
        cmp_word(got, (d1 & ~lo) | (d3 & lo));
        $display("test lanes done");
    endtask : t_lanes

    task automatic t_groups;
        issue(1, 0, 5'h1f, 11'h012, 9'h0aa, d4);
        f0 = falls0;
        f1 = falls1;
        issue(0, 0, 5'h1c, 11'h012, 9'h0aa, '0);
        cmp_int(falls0 - f0, 0);
        cmp_int(falls1 - f1, 1);
        cmp_word(got & ~lo, d4 & ~lo);
        f0 = falls0;
        issue(0, 0, 5'h03, 11'h012, 9'h0aa, '0);
        cmp_int(falls0 - f0, 1);
        cmp_word(got & lo, d4 & lo);
        issue(0, 0, 5'h1f, 11'h012, 9'h1c4, '0);
        cmp_word(got, 36'h0);
        cmp_int(model_err, 0);
        $display("test groups done");
    endtask : t_groups

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    initial
    begin
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_miss_hit();
        t_refresh();
        t_lanes();
        t_groups();
        stop_test();
    end

    initial
    begin
        #100000;
        miscompares++;
        stop_test();
    end
endmodule : cdmc_ctrl_bench

`default_nettype wire
